// ==== design/tdb_pkg.sv ====
// shared constants and types for the tape drive dma bridge
package tdb_pkg;
	// ==========================================================
	// register bus geometry
	localparam int TDB_AW = 8;
	localparam logic [7:0] TDB_ADDR_CTRL = 8'h00;
	localparam logic [7:0] TDB_ADDR_STAT = 8'h04;
	localparam logic [7:0] TDB_ADDR_CMD = 8'h08;
	localparam logic [7:0] TDB_ADDR_IRQ = 8'h0C;
	localparam logic [7:0] TDB_ADDR_CNT = 8'h10;
	localparam logic [1:0] TDB_RESP_OKAY = 2'h0;
	localparam logic [1:0] TDB_RESP_SLVERR = 2'h2;
	// ==========================================================
	// drive control register fields
	localparam int TDB_CTL_W = 4;
	localparam int TDB_CTL_DRIVE_CTL_A = 0;
	localparam int TDB_CTL_RESET = 1;
	localparam logic [3:0] TDB_CTL_RST_VAL = 4'h0;
	// ==========================================================
	// synchroniser vector layout: data byte then control lines
	localparam int TDB_SY_W = 12;
	localparam int TDB_SY_ACK = 8;
	localparam int TDB_SY_RDY = 9;
	localparam int TDB_SY_EXC = 10;
	localparam int TDB_SY_DIR = 11;
	localparam logic [11:0] TDB_SY_RST_VAL = 12'hF00;
	// ==========================================================
	// command decode and block geometry
	localparam logic [7:0] TDB_CMD_WRITE = 8'h40;
	localparam logic [7:0] TDB_CMD_READ = 8'h80;
	localparam int TDB_BLOCK_BYTES = 512;
	localparam logic [7:0] TDB_LAST_WORD = 8'hFF;
	localparam logic [7:0] TDB_MAX_BLOCKS = 8'hFA;
	// ==========================================================
	// modes and state machines
	typedef enum logic [1:0] {
		TDB_MODE_NONE = 2'b00,
		TDB_MODE_WR = 2'b01,
		TDB_MODE_RD = 2'b10
	} tdb_mode_t;
	typedef enum logic [1:0] {
		TDB_RQ_IDLE = 2'b00,
		TDB_RQ_ASSERT = 2'b01,
		TDB_RQ_RELEASE = 2'b10
	} tdb_rq_t;
	typedef enum logic [1:0] {
		TDB_XF_IDLE = 2'b00,
		TDB_XF_DRQ = 2'b01,
		TDB_XF_STB = 2'b10,
		TDB_XF_REL = 2'b11
	} tdb_xf_t;
endpackage

// ==== design/tdb_bridge.sv ====
// tape drive dma bridge: register slave, command request, byte/word data path
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - control register low nibble drives drive_ctl_a, reset
// - drive_ctl_a held low during data operations
// - control bit drives active-low drive reset
// - status low nibble returns control register
// - status high nibble returns synced drive lines
// - direction low drive-to-host, high host-to-drive
// - drive inputs pass two-flop synchroniser first
// - request generator times command, raises interrupt
// - command decode gated by request phase
// - mode and direction give read/write enables
// - write: dma request, latch low, high, repeat
// - terminal count blocks requests, clears mode
// - read: collect word then raise dma request
// - byte pointer fills latches; iord enables output
// - sixteen-bit host words, eight-bit drive bytes
// - blocks of 512 bytes, 256 words
// - one command moves 1 to 250 blocks
// - both read bytes presented as one word
// - write latches driven only when direction writes
// - interrupt acknowledge access clears pending interrupt
// - exception during command raises interrupt
module tdb_bridge
	import tdb_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// axi4-lite write address and data
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [TDB_AW-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	// axi4-lite write response
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	output logic [1:0] o_s_axi_bresp,
	// axi4-lite read
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	input wire logic [TDB_AW-1:0] i_s_axi_araddr,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	// host dma channel
	output logic o_dma_req,
	input wire logic i_dma_ack,
	input wire logic i_dma_tc,
	input wire logic i_dma_iord,
	input wire logic [15:0] i_dma_wdata,
	output logic [15:0] o_dma_rdata,
	// host interrupt
	output logic o_irq,
	// drive data bus, two-way
	input wire logic [7:0] i_drive_data,
	output logic [7:0] o_drive_data,
	output logic o_drive_data_oe_n,
	// drive control lines
	output logic o_drive_drive_ctl_a_n,
	output logic o_drive_reset_n,
	output logic o_drive_xfer_strobe_n,
	output logic o_drive_cmd_req_n,
	// drive status lines, asynchronous
	input wire logic i_drive_ack_n,
	input wire logic i_drive_ready_n,
	input wire logic i_drive_exception_n,
	input wire logic i_drive_direction_n
);
	// ==========================================================
	// input synchroniser
	logic [TDB_SY_W-1:0] sy_meta_r; // first stage, read only by second
	logic [TDB_SY_W-1:0] sy_r; // second stage
	// two flops before anything looks at a drive line
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			sy_meta_r <= TDB_SY_RST_VAL;
			sy_r <= TDB_SY_RST_VAL;
		end
		else
		begin
			sy_meta_r <= {i_drive_direction_n, i_drive_exception_n,
				i_drive_ready_n, i_drive_ack_n, i_drive_data};
			sy_r <= sy_meta_r;
		end
	end
	wire logic ack_synced_n = sy_r[TDB_SY_ACK];
	wire logic ready_synced_n = sy_r[TDB_SY_RDY];
	wire logic exc_synced_n = sy_r[TDB_SY_EXC];
	wire logic direction_synced_n = sy_r[TDB_SY_DIR];
	wire logic [7:0] drive_byte = sy_r[7:0];

	// ==========================================================
	// axi4-lite write channel
	logic aw_got_r; // address held
	logic w_got_r; // data held
	logic [TDB_AW-1:0] aw_addr_r;
	logic [7:0] w_byte_r; // only the low lane matters here
	logic w_lane0_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	wire logic aw_hs = i_s_axi_awvalid & awready_r;
	wire logic w_hs = i_s_axi_wvalid & wready_r;
	// commit only from held copies, so aw and w may come in any order
	wire logic wr_fire = aw_got_r & w_got_r & ~bvalid_r;
	wire logic aw_got_nxt = (aw_got_r | aw_hs) & ~wr_fire;
	wire logic w_got_nxt = (w_got_r | w_hs) & ~wr_fire;
	wire logic bvalid_nxt = wr_fire | (bvalid_r & ~i_s_axi_bready);
	wire logic [7:0] wa = {aw_addr_r[TDB_AW-1:2], 2'b00};
	wire logic wsel_ctl = (wa == TDB_ADDR_CTRL);
	wire logic wsel_cmd = (wa == TDB_ADDR_CMD);
	wire logic wsel_irq = (wa == TDB_ADDR_IRQ);
	wire logic wsel_ro = (wa == TDB_ADDR_STAT) | (wa == TDB_ADDR_CNT);
	wire logic wsel_ok = wsel_ctl | wsel_cmd | wsel_irq | wsel_ro;
	// handshakes and response
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= '0;
			w_byte_r <= 8'h00;
			w_lane0_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= TDB_RESP_OKAY;
		end
		else
		begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awready_r <= ~aw_got_nxt & ~bvalid_nxt;
			wready_r <= ~w_got_nxt & ~bvalid_nxt;
			bvalid_r <= bvalid_nxt;
			if (aw_hs)
				aw_addr_r <= i_s_axi_awaddr;
			if (w_hs)
			begin
				w_byte_r <= i_s_axi_wdata[7:0];
				w_lane0_r <= i_s_axi_wstrb[0];
			end
			if (wr_fire)
				bresp_r <= wsel_ok ? TDB_RESP_OKAY : TDB_RESP_SLVERR;
		end
	end

	// ==========================================================
	// control, command and interrupt state
	logic [TDB_CTL_W-1:0] ctl_r; // drive control register
	logic [7:0] cmd_r; // last command byte
	tdb_mode_t data_mode_sel;
	tdb_rq_t rq_r;
	tdb_xf_t xf_r;
	tdb_xf_t xf_nxt;
	logic irq_pend_r;
	logic exc_prev_r;
	logic tc_seen_r; // terminal count arrived with the last word
	logic ptr_r; // byte pointer, 0 low, 1 high
	logic [7:0] wlo_r, whi_r, rlo_r, rhi_r;
	logic [7:0] word_cnt_r;
	logic [7:0] block_cnt_r;
	// a command is accepted only when no command or data phase runs
	wire logic cmd_idle = (rq_r == TDB_RQ_IDLE) & (data_mode_sel == TDB_MODE_NONE);
	wire logic wr_ctl = wr_fire & wsel_ctl & w_lane0_r;
	wire logic wr_cmd = wr_fire & wsel_cmd & w_lane0_r & cmd_idle;
	wire logic irq_ack_access = wr_fire & wsel_irq;
	// request generator: hold request until ready, then release
	wire logic write_request = (rq_r == TDB_RQ_ASSERT);
	wire logic rq_take = write_request & ~ready_synced_n;
	wire logic rq_done = (rq_r == TDB_RQ_RELEASE) & ready_synced_n;
	// decode happens while the request phase is open
	wire tdb_mode_t cmd_mode = (cmd_r == TDB_CMD_WRITE) ? TDB_MODE_WR :
		(cmd_r == TDB_CMD_READ) ? TDB_MODE_RD : TDB_MODE_NONE;
	wire tdb_rq_t rq_nxt = wr_cmd ? TDB_RQ_ASSERT :
		rq_take ? TDB_RQ_RELEASE :
		rq_done ? TDB_RQ_IDLE : rq_r;
	// enables come from mode and synced direction together
	wire logic write_op_en = (data_mode_sel == TDB_MODE_WR) & direction_synced_n;
	wire logic read_op_en = (data_mode_sel == TDB_MODE_RD) & ~direction_synced_n;
	wire logic in_wr = (data_mode_sel == TDB_MODE_WR);
	wire logic dack_hit = (xf_r == TDB_XF_DRQ) & i_dma_ack;
	wire logic write_low_latch_en = dack_hit & in_wr;
	wire logic write_high_latch_en = dack_hit & in_wr;
	wire logic byte_acked = (xf_r == TDB_XF_REL) & ack_synced_n;
	wire logic read_low_byte_clk = (xf_r == TDB_XF_STB) & ~ack_synced_n & ~in_wr & ~ptr_r;
	wire logic read_high_byte_clk = (xf_r == TDB_XF_STB) & ~ack_synced_n & ~in_wr & ptr_r;
	// end of operation: after tc, a write finishes its word, a read its dack
	wire logic data_mode_abort = (byte_acked & ptr_r & in_wr & tc_seen_r) |
		(dack_hit & ~in_wr & i_dma_tc);
	wire logic write_dma_req_block_n = ~(in_wr & tc_seen_r);
	wire logic read_dma_req_block_n = ~(~in_wr & data_mode_abort);
	wire logic cmd_active = ~cmd_idle;
	wire logic exc_fall = exc_prev_r & ~exc_synced_n;
	wire logic irq_set = (rq_done & (cmd_mode == TDB_MODE_NONE)) | data_mode_abort |
		(exc_fall & cmd_active);
	wire logic word_done = dack_hit;
	wire logic block_wrap = word_done & (word_cnt_r == TDB_LAST_WORD);

	// data state machine, shared by both directions
	always_comb
	begin
		xf_nxt = xf_r;
		unique case (xf_r)
			TDB_XF_IDLE:
			begin
				if (write_op_en)
					xf_nxt = TDB_XF_DRQ;
				else if (read_op_en)
					xf_nxt = TDB_XF_STB;
			end
			TDB_XF_DRQ:
			begin
				// a write sends the word, a read waits for the next word
				if (dack_hit)
					xf_nxt = data_mode_abort ? TDB_XF_IDLE : TDB_XF_STB;
			end
			TDB_XF_STB:
			begin
				if (~ack_synced_n)
					xf_nxt = TDB_XF_REL;
			end
			TDB_XF_REL:
			begin
				if (byte_acked & ~ptr_r)
					xf_nxt = TDB_XF_STB;
				else if (byte_acked & data_mode_abort)
					xf_nxt = TDB_XF_IDLE;
				else if (byte_acked)
					xf_nxt = TDB_XF_DRQ;
			end
		endcase
	end
	wire logic dma_req_nxt = (xf_nxt == TDB_XF_DRQ) & write_dma_req_block_n &
		read_dma_req_block_n;

	// control register and command byte
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			ctl_r <= TDB_CTL_RST_VAL;
			cmd_r <= 8'h00;
		end
		else
		begin
			if (wr_ctl)
				ctl_r <= w_byte_r[TDB_CTL_W-1:0];
			if (wr_cmd)
				cmd_r <= w_byte_r;
		end
	end

	// request generator, mode and interrupt; set wins over ack
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			rq_r <= TDB_RQ_IDLE;
			data_mode_sel <= TDB_MODE_NONE;
			irq_pend_r <= 1'b0;
			exc_prev_r <= 1'b1;
		end
		else
		begin
			rq_r <= rq_nxt;
			exc_prev_r <= exc_synced_n;
			irq_pend_r <= irq_set | (irq_pend_r & ~irq_ack_access);
			if (data_mode_abort)
				data_mode_sel <= TDB_MODE_NONE;
			else if (rq_take)
				data_mode_sel <= cmd_mode;
		end
	end

	// data path state, pointer and latches
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			xf_r <= TDB_XF_IDLE;
			ptr_r <= 1'b0;
			tc_seen_r <= 1'b0;
			wlo_r <= 8'h00;
			whi_r <= 8'h00;
			rlo_r <= 8'h00;
			rhi_r <= 8'h00;
		end
		else
		begin
			xf_r <= xf_nxt;
			if (xf_r == TDB_XF_IDLE)
				ptr_r <= 1'b0;
			else if (byte_acked)
				ptr_r <= ~ptr_r;
			if (wr_cmd)
				tc_seen_r <= 1'b0;
			else if (write_low_latch_en)
				tc_seen_r <= i_dma_tc;
			if (write_low_latch_en)
				wlo_r <= i_dma_wdata[7:0];
			if (write_high_latch_en)
				whi_r <= i_dma_wdata[15:8];
			if (read_low_byte_clk)
				rlo_r <= drive_byte;
			if (read_high_byte_clk)
				rhi_r <= drive_byte;
		end
	end

	// word and block counters, cleared by each new command
	always_ff @(posedge i_clock)
	begin
		if (i_rst | wr_cmd)
		begin
			word_cnt_r <= 8'h00;
			block_cnt_r <= 8'h00;
		end
		else
		begin
			if (word_done)
				word_cnt_r <= word_cnt_r + 8'h01;
			if (block_wrap & (block_cnt_r != TDB_MAX_BLOCKS))
				block_cnt_r <= block_cnt_r + 8'h01;
		end
	end

	// ==========================================================
	// axi4-lite read channel
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	wire logic ar_hs = i_s_axi_arvalid & arready_r;
	wire logic rvalid_nxt = ar_hs | (rvalid_r & ~i_s_axi_rready);
	wire logic [7:0] ra = {i_s_axi_araddr[TDB_AW-1:2], 2'b00};
	wire logic [7:0] stat_byte = {direction_synced_n, exc_synced_n, ready_synced_n,
		ack_synced_n, ctl_r};
	wire logic rsel_ok = (ra == TDB_ADDR_CTRL) | (ra == TDB_ADDR_STAT) |
		(ra == TDB_ADDR_CMD) | (ra == TDB_ADDR_IRQ) | (ra == TDB_ADDR_CNT);
	wire logic [31:0] rd_word = (ra == TDB_ADDR_CTRL) ? {28'h0000000, ctl_r} :
		(ra == TDB_ADDR_STAT) ? {24'h000000, stat_byte} :
		(ra == TDB_ADDR_CMD) ? {24'h000000, cmd_r} :
		(ra == TDB_ADDR_IRQ) ? {31'h00000000, irq_pend_r} :
		(ra == TDB_ADDR_CNT) ? {16'h0000, block_cnt_r, word_cnt_r} : 32'h00000000;
	// read data is captured when the address is taken
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= TDB_RESP_OKAY;
		end
		else
		begin
			arready_r <= ~rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (ar_hs)
			begin
				rdata_r <= rd_word;
				rresp_r <= rsel_ok ? TDB_RESP_OKAY : TDB_RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// registered outputs toward drive and dma
	logic drive_ctl_a_n_r, reset_n_r, strobe_n_r, req_n_r, oe_n_r, dma_req_r;
	logic [7:0] dout_r;
	logic [15:0] dma_rdata_r;
	// drive strobe trails the state by one cycle; ack is awaited anyway
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			drive_ctl_a_n_r <= 1'b1;
			reset_n_r <= 1'b1;
			strobe_n_r <= 1'b1;
			req_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			dout_r <= 8'h00;
			dma_req_r <= 1'b0;
			dma_rdata_r <= 16'h0000;
		end
		else
		begin
			drive_ctl_a_n_r <= ~(ctl_r[TDB_CTL_DRIVE_CTL_A] | (data_mode_sel != TDB_MODE_NONE));
			reset_n_r <= ~ctl_r[TDB_CTL_RESET];
			strobe_n_r <= ~(xf_r == TDB_XF_STB);
			req_n_r <= ~write_request;
			oe_n_r <= ~(write_request | (in_wr & direction_synced_n & xf_r[1]));
			dout_r <= write_request ? cmd_r : (ptr_r ? whi_r : wlo_r);
			dma_req_r <= dma_req_nxt;
			// word leaves only under the dma read strobe
			dma_rdata_r <= (dack_hit & i_dma_iord & ~in_wr) ? {rhi_r, rlo_r} : 16'h0000;
		end
	end
	assign o_s_axi_awready = awready_r;
	assign o_s_axi_wready = wready_r;
	assign o_s_axi_bvalid = bvalid_r;
	assign o_s_axi_bresp = bresp_r;
	assign o_s_axi_arready = arready_r;
	assign o_s_axi_rvalid = rvalid_r;
	assign o_s_axi_rdata = rdata_r;
	assign o_s_axi_rresp = rresp_r;
	assign o_dma_req = dma_req_r;
	assign o_dma_rdata = dma_rdata_r;
	assign o_irq = irq_pend_r;
	assign o_drive_data = dout_r;
	assign o_drive_data_oe_n = oe_n_r;
	assign o_drive_drive_ctl_a_n = drive_ctl_a_n_r;
	assign o_drive_reset_n = reset_n_r;
	assign o_drive_xfer_strobe_n = strobe_n_r;
	assign o_drive_cmd_req_n = req_n_r;

	// ==========================================================
	// assertions
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	a_drive_ctl_a_held: assert property ((data_mode_sel != TDB_MODE_NONE) |=> !o_drive_drive_ctl_a_n)
		else $error("drive_ctl_a released during data operation");
	a_reset_follows: assert property (ctl_r[TDB_CTL_RESET] |=> !o_drive_reset_n)
		else $error("drive reset not driven from control");
	// a data command interrupts at terminal count, not when its request phase closes
	a_cmd_irq: assert property (rq_done && (cmd_mode == TDB_MODE_NONE) |=> o_irq)
		else $error("no interrupt at end of command");
	a_irq_clear: assert property (irq_ack_access && !irq_set |=> !o_irq)
		else $error("interrupt acknowledge did not clear");
	a_exc_irq: assert property (exc_fall && cmd_active |=> o_irq)
		else $error("exception did not raise interrupt");
	a_tc_block: assert property (data_mode_abort |=> !o_dma_req [*2])
		else $error("dma request after terminal count");
	a_tc_mode: assert property (data_mode_abort |=> data_mode_sel == TDB_MODE_NONE)
		else $error("mode not cleared at terminal count");
	a_rd_gate: assert property (!(dack_hit && i_dma_iord) |=> o_dma_rdata == 16'h0000)
		else $error("read latch driven without read strobe");
	a_dir_gate: assert property ((data_mode_sel == TDB_MODE_RD) && !write_request |=> o_drive_data_oe_n)
		else $error("drive bus driven during read");
	a_ptr_step: assert property (byte_acked && !ptr_r |=> ptr_r && xf_r == TDB_XF_STB)
		else $error("pointer did not advance after acknowledge");
	a_req_phase: assert property (wr_cmd |=> write_request ##1 !o_drive_cmd_req_n)
		else $error("command request not raised");
	c_write_op: cover property (write_op_en ##[1:200] data_mode_abort);
	c_read_op: cover property (read_op_en ##[1:200] data_mode_abort);
	c_irq_ack: cover property (o_irq ##1 irq_ack_access);
	c_exception: cover property (exc_fall && cmd_active);
endmodule // tdb_bridge
`default_nettype wire

// ==== sim/tdb_drive_model.sv ====
// behavioural tape drive facing the bridge
`timescale 1ns/1ps
`default_nettype none
module tdb_drive_model
(
	// clock and scenario controls
	input wire logic i_clock,
	input wire logic [2:0] i_lat,
	input wire logic i_hold_ready,
	input wire logic i_dir_n,
	input wire logic i_exc_n,
	input wire logic [7:0] i_rd_seed,
	// lines from the bridge
	input wire logic i_reset_n,
	input wire logic i_cmd_req_n,
	input wire logic i_xfer_strobe_n,
	input wire logic [7:0] i_bus,
	input wire logic i_bus_oe_n,
	// lines to the bridge
	output logic o_ack_n,
	output logic o_ready_n,
	output logic o_exception_n,
	output logic o_direction_n,
	output logic [7:0] o_bus,
	output logic [15:0] o_wr_cap
);
	logic [7:0] req_hist_r = 8'hFF; // request history, gives a variable reply delay
	logic [7:0] stb_hist_r = 8'hFF; // strobe history
	logic [7:0] rd_idx_r = 8'h00; // bytes handed out so far
	logic [7:0] bus_r = 8'h00; // bus value, toggles while not driven
	// ==========================================================
	// static lines come straight from the bench
	assign o_direction_n = i_dir_n;
	assign o_exception_n = i_exc_n;
	assign o_bus = bus_r;
	// ==========================================================
	// replies lag the bridge by i_lat+2 cycles, so prompt and slow drives are both covered
	always_ff @(posedge i_clock)
	begin
		req_hist_r <= {req_hist_r[6:0], i_cmd_req_n};
		stb_hist_r <= {stb_hist_r[6:0], i_xfer_strobe_n};
		// ready only once the request was seen and nothing holds it back
		o_ready_n <= !i_reset_n | i_hold_ready | req_hist_r[i_lat];
		o_ack_n <= !i_reset_n | stb_hist_r[i_lat];
		// take a byte one cycle into the strobe, only while the bridge drives
		if (stb_hist_r[1:0] == 2'h2 && !i_xfer_strobe_n && !i_bus_oe_n)
			o_wr_cap <= {i_bus, o_wr_cap[15:8]};
		// released bus must not look like the last byte
		if (!i_dir_n && !i_xfer_strobe_n)
			bus_r <= i_rd_seed + rd_idx_r;
		else
			bus_r <= ~bus_r;
		if (!i_dir_n && !stb_hist_r[0] && i_xfer_strobe_n)
			rd_idx_r <= rd_idx_r + 8'h01;
	end
endmodule // tdb_drive_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the tape drive dma bridge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import tdb_pkg::*;
	// ==========================================================
	// stimulus and observed signals
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic aw_valid = 1'h0, w_valid = 1'h0, b_ready = 1'h0, ar_valid = 1'h0, r_ready = 1'h0;
	logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
	logic [31:0] w_data = 32'h0;
	logic [3:0] w_strb = 4'hF;
	logic dma_ack = 1'h0, dma_tc = 1'h0, dma_iord = 1'h0;
	logic [15:0] dma_wdata = 16'h0;
	logic [2:0] lat = 3'h1;
	logic hold = 1'h0, dir_n = 1'h1, exc_n = 1'h1;
	logic [7:0] seed = 8'h00;
	wire logic aw_ready, w_ready, b_valid, ar_ready, r_valid, dma_req, irq, oe_n;
	wire logic drive_ctl_a_n, reset_n, strobe_n, req_n, ack_n, ready_n, exc_w_n, dir_w_n;
	wire logic [1:0] b_resp, r_resp;
	wire logic [31:0] r_data;
	wire logic [15:0] dma_rdata, wr_cap;
	wire logic [7:0] dut_bus, mdl_bus, bus;
	logic [31:0] rd_data;
	logic [15:0] got;
	int failures = 0;
	int n_compared = 0;
	// whoever enables wins the shared drive bus
	assign bus = oe_n ? mdl_bus : dut_bus;
	// ==========================================================
	// block under test and the drive beside it
	tdb_bridge tdb_bridge_inst (.i_clock(clk), .i_rst(rst), .i_s_axi_awvalid(aw_valid),
		.o_s_axi_awready(aw_ready), .i_s_axi_awaddr(aw_addr), .i_s_axi_wvalid(w_valid),
		.o_s_axi_wready(w_ready), .i_s_axi_wdata(w_data), .i_s_axi_wstrb(w_strb),
		.o_s_axi_bvalid(b_valid), .i_s_axi_bready(b_ready), .o_s_axi_bresp(b_resp),
		.i_s_axi_arvalid(ar_valid), .o_s_axi_arready(ar_ready), .i_s_axi_araddr(ar_addr),
		.o_s_axi_rvalid(r_valid), .i_s_axi_rready(r_ready), .o_s_axi_rdata(r_data),
		.o_s_axi_rresp(r_resp), .o_dma_req(dma_req), .i_dma_ack(dma_ack), .i_dma_tc(dma_tc),
		.i_dma_iord(dma_iord), .i_dma_wdata(dma_wdata), .o_dma_rdata(dma_rdata), .o_irq(irq),
		.i_drive_data(bus), .o_drive_data(dut_bus), .o_drive_data_oe_n(oe_n),
		.o_drive_drive_ctl_a_n(drive_ctl_a_n), .o_drive_reset_n(reset_n), .o_drive_xfer_strobe_n(strobe_n),
		.o_drive_cmd_req_n(req_n), .i_drive_ack_n(ack_n), .i_drive_ready_n(ready_n),
		.i_drive_exception_n(exc_w_n), .i_drive_direction_n(dir_w_n));
	tdb_drive_model tdb_drive_model_inst (.i_clock(clk), .i_lat(lat), .i_hold_ready(hold),
		.i_dir_n(dir_n), .i_exc_n(exc_n), .i_rd_seed(seed), .i_reset_n(reset_n),
		.i_cmd_req_n(req_n), .i_xfer_strobe_n(strobe_n), .i_bus(dut_bus), .i_bus_oe_n(oe_n),
		.o_ack_n(ack_n), .o_ready_n(ready_n), .o_exception_n(exc_w_n), .o_direction_n(dir_w_n),
		.o_bus(mdl_bus), .o_wr_cap(wr_cap));
	// ==========================================================
	// clock and watchdog; a hang counts as a mismatch
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		#2000000;
		failures++;
		$display("[ERR] %0t watchdog expired", $time);
		finish_test();
	end
	// ==========================================================
	// shared helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
	begin
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	end
	endtask
	// one axi4-lite access; readys are sampled at the falling edge ahead of the edge that takes them
	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_t, w_t, ar_t, done;
		logic [1:0] resp;
		int n;
	begin
		@(posedge clk);
		aw_valid <= wr;
		w_valid <= wr;
		ar_valid <= !wr;
		aw_addr <= a;
		ar_addr <= a;
		w_data <= d;
		b_ready <= wr;
		r_ready <= !wr;
		done = 1'h0;
		for (n = 0; !done && n < 200; n++)
		begin
			@(negedge clk);
			aw_t = aw_valid & aw_ready;
			w_t = w_valid & w_ready;
			ar_t = ar_valid & ar_ready;
			done = wr ? (b_ready & b_valid) : (r_ready & r_valid);
			resp = wr ? b_resp : r_resp;
			rd_data = r_data;
			@(posedge clk);
			if (aw_t) aw_valid <= 1'h0;
			if (w_t) w_valid <= 1'h0;
			if (ar_t) ar_valid <= 1'h0;
		end
		b_ready <= 1'h0;
		r_ready <= 1'h0;
		chk({31'h0, done}, 32'h1);
		chk({30'h0, resp}, {30'h0, er});
	end
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: pick = irq;
			1: pick = req_n;
			default: pick = dma_req;
		endcase
	endfunction
	// bounded wait for a level, then compare it
	task automatic till(input int s, input logic v, input int lim);
		int n;
	begin
		@(negedge clk);
		for (n = 0; pick(s) !== v && n < lim; n++) @(negedge clk);
		chk({31'h0, pick(s)}, {31'h0, v});
	end
	endtask
	// one dma word: ack held a single cycle, read word sampled the cycle after
	task automatic dma(input logic [15:0] w, input logic tc, input logic rd);
	begin
		till(2, 1'h1, 2000);
		@(posedge clk);
		dma_ack <= 1'h1;
		dma_tc <= tc;
		dma_iord <= rd;
		dma_wdata <= w;
		@(posedge clk);
		dma_ack <= 1'h0;
		dma_tc <= 1'h0;
		dma_iord <= 1'h0;
		@(negedge clk);
		got = dma_rdata;
	end
	endtask
	task automatic finish_test();
	begin
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	// ==========================================================
	// test sequence
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		repeat (3) @(negedge clk);
		chk({25'h0, drive_ctl_a_n, reset_n, strobe_n, req_n, oe_n, irq, dma_req}, 32'h7C);
		acc(1'h0, TDB_ADDR_CTRL, 32'h0, TDB_RESP_OKAY);
		chk(rd_data, 32'h0);
		$display("test reset done");
		acc(1'h1, TDB_ADDR_CTRL, 32'h3, TDB_RESP_OKAY);
		repeat (2) @(negedge clk);
		chk({30'h0, drive_ctl_a_n, reset_n}, 32'h0);
		acc(1'h0, TDB_ADDR_STAT, 32'h0, TDB_RESP_OKAY);
		chk(rd_data, 32'hF3);
		w_strb <= 4'h0;
		acc(1'h1, TDB_ADDR_CTRL, 32'h1, TDB_RESP_OKAY);
		w_strb <= 4'hF;
		acc(1'h0, TDB_ADDR_CTRL, 32'h0, TDB_RESP_OKAY);
		chk(rd_data, 32'h3);
		acc(1'h1, TDB_ADDR_CTRL, 32'h0, TDB_RESP_OKAY);
		acc(1'h1, 8'h14, 32'h5, TDB_RESP_SLVERR);
		acc(1'h0, 8'h14, 32'h0, TDB_RESP_SLVERR);
		chk(rd_data, 32'h0);
		$display("test registers done");
		acc(1'h1, TDB_ADDR_CMD, 32'h01, TDB_RESP_OKAY);
		till(1, 1'h0, 20);
		chk({23'h0, oe_n, dut_bus}, 32'h01);
		till(1, 1'h1, 50);
		till(0, 1'h1, 50);
		acc(1'h0, TDB_ADDR_IRQ, 32'h0, TDB_RESP_OKAY);
		chk(rd_data, 32'h1);
		acc(1'h1, TDB_ADDR_IRQ, 32'h0, TDB_RESP_OKAY);
		acc(1'h0, TDB_ADDR_IRQ, 32'h0, TDB_RESP_OKAY);
		chk(rd_data, 32'h0);
		$display("test command done");
		lat <= 3'h5;
		acc(1'h1, TDB_ADDR_CMD, {24'h0, TDB_CMD_WRITE}, TDB_RESP_OKAY);
		dma(16'h1234, 1'h0, 1'h0);
		chk({31'h0, drive_ctl_a_n}, 32'h0);
		till(2, 1'h1, 2000);
		chk({16'h0, wr_cap}, 32'h1234);
		dma(16'hA55A, 1'h1, 1'h0);
		till(0, 1'h1, 2000);
		chk({16'h0, wr_cap}, 32'hA55A);
		repeat (20) @(negedge clk);
		chk({30'h0, dma_req, drive_ctl_a_n}, 32'h1);
		acc(1'h0, TDB_ADDR_CNT, 32'h0, TDB_RESP_OKAY);
		chk(rd_data, 32'h2);
		acc(1'h1, TDB_ADDR_IRQ, 32'h0, TDB_RESP_OKAY);
		$display("test write done");
		dir_n <= 1'h0;
		seed <= 8'h21;
		lat <= 3'h2;
		acc(1'h1, TDB_ADDR_CMD, {24'h0, TDB_CMD_READ}, TDB_RESP_OKAY);
		dma(16'h0, 1'h1, 1'h1);
		chk({16'h0, got}, 32'h2221);
		till(0, 1'h1, 2000);
		chk({31'h0, dma_req}, 32'h0);
		acc(1'h1, TDB_ADDR_IRQ, 32'h0, TDB_RESP_OKAY);
		$display("test read done");
		dir_n <= 1'h1;
		hold <= 1'h1;
		acc(1'h1, TDB_ADDR_CMD, 32'h02, TDB_RESP_OKAY);
		till(1, 1'h0, 20);
		@(posedge clk);
		exc_n <= 1'h0;
		till(0, 1'h1, 10);
		acc(1'h0, TDB_ADDR_STAT, 32'h0, TDB_RESP_OKAY);
		chk(rd_data, 32'hB0);
		exc_n <= 1'h0;
		hold <= 1'h0;
		till(1, 1'h1, 50);
		exc_n <= 1'h1;
		acc(1'h1, TDB_ADDR_IRQ, 32'h0, TDB_RESP_OKAY);
		$display("test exception done");
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
